// ===== bench/prspc_board.sv
`timescale 1ns/1ps
module prspc_board (
  input wire logic fiber, sd, loopback,
  output logic media_sel_sig_detect
);
  // Twisted pair ties the line low; loopback in fiber forces detect high
  assign media_sel_sig_detect = fiber & (sd | loopback);
endmodule : prspc_board

// ===== bench/prspc_ctrl_asserts.sv
`timescale 1ns/1ps
module prspc_ctrl_asserts (
  input wire logic pclk, presetn, psel, penable, pwrite, pready, hw_reset_n,
  input wire logic media_sel_sig_detect, sleep_in, power_down_in, mgmt_disable,
  input wire logic core_reset, fiber_mode, signal_detect, sleep_mode, power_down,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [4:0] addr_pins, mgmt_addr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pin_reset: assert property (!hw_reset_n [*8] |-> core_reset)
    else $error("no reset from pin");
  a_soft_reset: assert property (psel && penable && pready && pwrite && paddr == 12'h000
    && pwdata[15] && !mgmt_disable |-> ##[0:4] core_reset)
    else $error("no reset from soft bit");
  a_reset_stretch: assert property ($rose(hw_reset_n) |-> core_reset [*8])
    else $error("reset not stretched");
  a_media_strap: assert property ((core_reset && media_sel_sig_detect) [*8] |-> fiber_mode)
    else $error("fiber strap lost");
  a_detect_pass: assert property ((fiber_mode && media_sel_sig_detect && !core_reset) [*8]
    |-> signal_detect)
    else $error("signal detect lost");
  a_addr_take: assert property ($stable(addr_pins) [*8] |-> mgmt_addr == addr_pins)
    else $error("address mismatch");
  a_sleep_pin: assert property (sleep_in [*8] ##0 mgmt_disable |-> sleep_mode)
    else $error("sleep pin ignored");
  a_power_down: assert property (power_down_in [*8] |-> power_down)
    else $error("power down ignored");
endmodule : prspc_ctrl_asserts
bind prspc_ctrl prspc_ctrl_asserts chk_u (.*);

// ===== bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic hw_reset_n = 1, fiber = 0, sd = 1, sleep_in = 0, power_down_in = 0;
  logic mgmt_disable = 0, media_sel_sig_detect, core_reset, fiber_mode, signal_detect;
  logic sleep_mode, power_down, loopback;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [4:0] addr_pins = 0, mgmt_addr;
  logic [15:0] seed = 16'h6374;
  logic [32:0] exp_q[$];
  int n_mismatch = 0, samples_checked = 0;
  initial forever #2.5 pclk = ~pclk;
  prspc_ctrl #(.STRETCH_CYC(20)) dut_u (.*);
  prspc_board board_u (.*);
  function automatic logic [15:0] xs(logic [15:0] s);
    s ^= s << 7;
    s ^= s >> 9;
    return s ^ (s << 8);
  endfunction : xs
  task chk(logic [32:0] got, logic [32:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  always @(negedge pclk) if (psel && penable && pready === 1'b1 && !pwrite) begin
    chk({pslverr, prdata}, exp_q.pop_front());
  end
  task apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask : apb
  task rd(logic [11:0] a, logic [32:0] e);
    exp_q.push_back(e);
    apb(0, a, 0);
  endtask : rd
  task settle(string s);
    repeat (8) @(posedge pclk);
    for (int i = 0; i < 99 && core_reset !== 1'b0; i++) @(posedge pclk);
    $display("test %s done", s);
  endtask : settle
  task results;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  initial begin
    #20000;
    n_mismatch++;
    results();
  end
  initial begin
    seed = xs(seed);
    repeat (8) @(posedge pclk);
    presetn <= 1;
    addr_pins <= seed[4:0];
    hw_reset_n <= 0;
    repeat (8) @(posedge pclk);
    hw_reset_n <= 1;
    settle("pin");
    rd(12'h008, 33'h0_0000_0800 | addr_pins);
    rd(12'h004, 33'h0_0000_0000);
    rd(12'h00c, 33'h1_0000_0000);
    fiber <= 1;
    apb(1, 12'h000, 32'h0000_8000);
    settle("soft");
    rd(12'h004, 33'h0_0000_0001);
    rd(12'h008, 33'h0_0000_0900 | addr_pins);
    sd <= 0;
    settle("detect");
    rd(12'h008, 33'h0_0000_0800 | addr_pins);
    sleep_in <= 1;
    power_down_in <= 1;
    mgmt_disable <= 1;
    settle("pins");
    rd(12'h008, 33'h0_0000_0e00 | addr_pins);
    // Locked writes must leave the mode untouched
    apb(1, 12'h004, 32'h0000_0080);
    rd(12'h004, 33'h0_0000_0001);
    mgmt_disable <= 0;
    power_down_in <= 0;
    // Unlock must pass the pin filter before the write counts
    repeat (8) @(posedge pclk);
    apb(1, 12'h004, 32'h0000_0081);
    settle("override");
    rd(12'h008, 33'h0_0000_0800 | addr_pins);
    results();
  end
endmodule : testbench

// ===== logic/prspc_ctrl.sv
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
// Behaviour
// - At reset sample media strap: high sets fiber mode, low twisted-pair.
// - In fiber mode after reset, the strap pin becomes signal detect.
// - Reset active when hardware reset pin low OR software reset bit set.
// - Internal reset stretched 258 us after the reset source releases.
// - Management address taken from five address pins, bits 4 to 0.
// - Sleep pin enables sleep; software may override it in managed mode.
// - Power-down pin high enters power-down and holds while high.
// - With management on, pins set fiber mode and sleep defaults that software may rewrite; power-down follows its pin, address latches in reset only.
`include "prspc_params.svh"
module prspc_ctrl
  import prspc_pkg::*;
#(
  parameter int STRETCH_CYC = `PRSPC_STRETCH_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hw_reset_n,
  input wire logic media_sel_sig_detect,
  input wire logic [4:0] addr_pins,
  input wire logic sleep_in,
  input wire logic power_down_in,
  input wire logic mgmt_disable,
  output logic core_reset,
  output logic fiber_mode,
  output logic signal_detect,
  output logic [4:0] mgmt_addr,
  output logic sleep_mode,
  output logic power_down,
  output logic loopback
);
  // ----------------------------------------
  // Pin synchronisers, three stages
  // ----------------------------------------
  localparam int NPIN = 10;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1;
  logic [NPIN-1:0] sync2;
  logic [NPIN-1:0] sync3;
  logic [NPIN-1:0] pin;
  assign pin_raw = {mgmt_disable, power_down_in, sleep_in, addr_pins,
                    media_sel_sig_detect, hw_reset_n};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      pin <= '0;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      // Accept a change only once two stages agree
      for (int i = 0; i < NPIN; i++) begin
        if (sync2[i] == sync3[i]) begin
          pin[i] <= sync3[i];
        end
      end
    end
  end
  logic hw_rst_pin;
  assign hw_rst_pin = ~pin[0];

  // ----------------------------------------
  // Management lock
  // ----------------------------------------
  // Lock follows the filtered pin, so a glitch cannot open a write window
  logic mgmt_locked;
  assign mgmt_locked = pin[9];

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic sw_reset;
  logic sleep_ovr_en;
  logic sleep_ovr_val;
  logic apb_wr;
  logic apb_rd;
  prspc_state_t state;
  logic [31:0] cnt;
  logic rst_src;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;
  assign rst_src = hw_rst_pin | sw_reset;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_reset <= 1'b0;
      loopback <= 1'b0;
    end else if (state == PRSPC_ST_RESET) begin
      // Self-clearing: the reset it starts clears it
      sw_reset <= 1'b0;
      loopback <= 1'b0;
    end else if (apb_wr && paddr == `PRSPC_CTRL_OFS && !mgmt_locked) begin
      sw_reset <= pwdata[`PRSPC_CTRL_SWRST_BIT];
      loopback <= pwdata[`PRSPC_CTRL_LOOP_BIT];
    end
  end

  // ----------------------------------------
  // Reset sequencer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= PRSPC_ST_RESET;
      cnt <= '0;
    end else begin
      unique case (state)
        PRSPC_ST_RESET: begin
          cnt <= '0;
          if (!rst_src) begin
            state <= PRSPC_ST_STRETCH;
          end
        end
        PRSPC_ST_STRETCH: begin
          if (rst_src) begin
            state <= PRSPC_ST_RESET;
          end else if (cnt == 32'(STRETCH_CYC - 1)) begin
            state <= PRSPC_ST_RUN;
          end else begin
            cnt <= cnt + 32'h0000_0001;
          end
        end
        PRSPC_ST_RUN: begin
          if (rst_src) begin
            state <= PRSPC_ST_RESET;
          end
        end
        // Spare code: fall back into reset rather than lock up
        default: begin
          state <= PRSPC_ST_RESET;
          cnt <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Strap capture and mode bits
  // ----------------------------------------
  // Straps are relatched through the whole reset, so the last value wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fiber_mode <= 1'b0;
      mgmt_addr <= '0;
      sleep_ovr_en <= 1'b0;
      sleep_ovr_val <= 1'b0;
    end else if (state != PRSPC_ST_RUN) begin
      fiber_mode <= pin[1];
      mgmt_addr <= pin[6:2];
      sleep_ovr_en <= 1'b0;
      sleep_ovr_val <= 1'b0;
    end else if (apb_wr && paddr == `PRSPC_MODE_OFS && !mgmt_locked) begin
      fiber_mode <= pwdata[`PRSPC_MODE_FIBER_BIT];
      sleep_ovr_val <= pwdata[`PRSPC_MODE_SLPOVR_BIT];
      sleep_ovr_en <= pwdata[`PRSPC_MODE_SLPEN_BIT];
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_reset <= 1'b1;
      signal_detect <= 1'b0;
      sleep_mode <= 1'b0;
      power_down <= 1'b0;
    end else begin
      core_reset <= (state != PRSPC_ST_RUN) | rst_src;
      // Twisted-pair boards hold the pin low, so detect stays off
      signal_detect <= (state == PRSPC_ST_RUN) && fiber_mode && pin[1];
      // Override only counts while software owns the bits
      sleep_mode <= (sleep_ovr_en && !mgmt_locked) ? sleep_ovr_val : pin[7];
      power_down <= pin[8];
    end
  end

  // ----------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // Answer is prepared in the setup cycle, so it stands in the access cycle
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(paddr == `PRSPC_CTRL_OFS ||
                 paddr == `PRSPC_MODE_OFS || paddr == `PRSPC_STAT_OFS);
      prdata <= '0;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          `PRSPC_CTRL_OFS: prdata <= {16'h0000, sw_reset, loopback, 14'h0000};
          `PRSPC_MODE_OFS: prdata <= {24'h0000_00, sleep_ovr_en, sleep_ovr_val,
                                      5'h00, fiber_mode};
          `PRSPC_STAT_OFS: prdata <= {16'h0000, 4'h0, state == PRSPC_ST_RUN,
                                      power_down, sleep_mode, signal_detect,
                                      3'h0, mgmt_addr};
          default: prdata <= '0;
        endcase
      end
    end
  end
  // Read data is fetched in setup, so the access strobe itself is spare
  logic unused_rd;
  assign unused_rd = apb_rd;
endmodule : prspc_ctrl

// ===== logic/prspc_params.svh
`ifndef PRSPC_PARAMS_SVH
`define PRSPC_PARAMS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PRSPC_CTRL_OFS 12'h000
`define PRSPC_MODE_OFS 12'h004
`define PRSPC_STAT_OFS 12'h008
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PRSPC_CTRL_SWRST_BIT 15
`define PRSPC_CTRL_LOOP_BIT 14
`define PRSPC_MODE_FIBER_BIT 0
`define PRSPC_MODE_SLPOVR_BIT 6
`define PRSPC_MODE_SLPEN_BIT 7
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define PRSPC_CTRL_RST 16'h0000
`define PRSPC_CLK_MHZ 200
`define PRSPC_STRETCH_US 258
`define PRSPC_STRETCH_CYC (`PRSPC_STRETCH_US * `PRSPC_CLK_MHZ)
`endif

// ===== logic/prspc_pkg.sv
package prspc_pkg;
  typedef enum logic [1:0] {
    PRSPC_ST_RESET,
    PRSPC_ST_STRETCH,
    PRSPC_ST_RUN
  } prspc_state_t;
endpackage : prspc_pkg
